//--- verilog/cftf_pkg.sv
// shared constants, types and register map of the charge-control state machine
package cftf_pkg;

  // timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int QUAL_SHORT_MS  = 16;
  localparam int QUAL_SHORT_CYC = CLK_HZ / 1000 * QUAL_SHORT_MS;
  localparam int TERM_QUAL_MS   = 750;
  localparam int TERM_QUAL_CYC  = CLK_HZ / 1000 * TERM_QUAL_MS;
  localparam int BLINK_HZ       = 1;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int SEC_CYC        = CLK_HZ;
  localparam int LB_LIMIT_MIN   = 120;
  localparam int LB_LIMIT_S     = LB_LIMIT_MIN * 60;
  localparam int FC_STEP_MIN    = 30;
  localparam logic [15:0] FC_STEP_S = 16'(FC_STEP_MIN * 60);

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VOLT = 8'h04;
  localparam logic [7:0] ADDR_CURR = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TMR  = 8'h10;

  // field positions
  localparam int CB_TERM    = 0;
  localparam int CB_TDIS    = 1;
  localparam int CB_VMASK   = 2;
  localparam int CB_RECH    = 3;
  localparam int CB_LIM_LO  = 4;
  localparam int CB_RESTART = 9;
  localparam int CUR_TERM   = 8;
  localparam int TMR_FC_LO  = 16;

  // reset values
  localparam logic [10:0] CHGV_RST    = 11'h400;
  localparam logic [6:0]  FASTCUR_RST = 7'h64;
  localparam logic [3:0]  TERMCUR_RST = 4'h2;
  localparam logic [4:0]  LIM_RST   = 5'h0B;

  typedef enum logic [2:0] {
    precondition_state, precondition_temp_hold, fast_charge_state, fast_temp_hold,
    charge_full_state, full_temp_hold, terminated_state, fault_state
  } cftf_state_t;

  // host settings
  typedef struct packed {
    logic        term_en;
    logic        therm_dis;
    logic        regulator_fault_mask;
    logic        recharge_offset;
    logic [4:0]  fast_timer_limit;
    logic [10:0] charge_voltage_field;
    logic [6:0]  fast_current_field;
    logic [3:0]  termination_current;
  } cftf_cfg_t;

  // comparator and pin flags from the analog side
  typedef struct packed {
    logic vbat_gt_low;
    logic vbat_at_reg;
    logic vbat_lt_good;
    logic vbat_lt_rech;
    logic icharge_lt_term;
    logic temp_hot;
    logic temp_cold;
    logic bat_ov;
    logic vin_uv;
    logic vin_ov;
    logic vreg_flt;
  } cftf_sense_t;

  localparam int SENSE_W = $bits(cftf_sense_t);

endpackage

//--- verilog/cftf_qualify.sv
// continuous-truth qualifier: done after LIM straight cycles of cond
`timescale 1ns/10ps
module cftf_qualify
  import cftf_pkg::*;
#(
  parameter int LIM = 16
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // condition
  input  wire logic clr,
  input  wire logic cond,
  // result
  output logic      done_r
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr || !cond) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r != 32'(LIM)) begin
      cnt_nxt = cnt_r + 32'h1;
    end
    done_nxt = (cnt_nxt == 32'(LIM));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= 32'h0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

//--- verilog/cftf_divider.sv
// cycle divider: one-cycle pulse every N cycles while run is high
`timescale 1ns/10ps
module cftf_divider
  import cftf_pkg::*;
#(
  parameter int N = 16
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic run,
  // tick
  output logic      pulse_r
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        pulse_nxt;

  always_comb begin
    cnt_nxt   = cnt_r + 32'h1;
    pulse_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r == 32'(N - 1)) begin
      cnt_nxt   = 32'h0;
      pulse_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= 32'h0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

endmodule

//--- verilog/cftf_charge_fsm.sv
// charge-control state machine from precondition through termination, AHB-Lite registers
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module cftf_charge_fsm
  import cftf_pkg::*;
#(
  parameter int QUAL_CYC  = QUAL_SHORT_CYC,
  parameter int TERM_CYC  = TERM_QUAL_CYC,
  parameter int SECOND    = SEC_CYC,
  parameter int BLINK_CYC = BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic         hready,
  input  wire logic [31:0]  hwdata,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // analog flags and status pin level
  input  wire cftf_sense_t  sense,
  input  wire logic         chg_stat_in,
  // status pin, open drain
  output logic              chg_stat_out,
  output logic              chg_stat_oe_n,
  // regulation control
  output logic              charge_en,
  output logic              cv_mode,
  output cftf_cfg_t         cfg_o,
  output cftf_state_t       state_o
);

  // pin synchronisers
  logic [SENSE_W:0] sync1_r;
  logic [SENSE_W:0] sync2_r;
  cftf_sense_t      sn;
  logic             pin_lvl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {chg_stat_in, sense};
      sync2_r <= sync1_r;
    end
  end

  assign sn      = sync2_r[SENSE_W-1:0];
  assign pin_lvl = sync2_r[SENSE_W];

  // bus and register state
  cftf_cfg_t   cfg_r, cfg_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        restart_r, restart_nxt;
  cftf_state_t state_r, state_nxt;
  logic [15:0] lb_sec_r, lb_sec_nxt;
  logic [15:0] fc_sec_r, fc_sec_nxt;
  logic        blink_r, blink_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        chg_en_r, chg_en_nxt;
  logic        cv_r, cv_nxt;
  logic        addr_ph;

  assign addr_ph = hsel && htrans[1] && hready;

  always_comb begin
    cfg_nxt     = cfg_r;
    wr_pend_nxt = addr_ph && hwrite;
    waddr_nxt   = addr_ph ? haddr[7:0] : waddr_r;
    rdata_nxt   = rdata_r;
    restart_nxt = 1'b0;
    if (wr_pend_r) begin
      unique case (waddr_r)
        ADDR_CTRL: begin
          cfg_nxt.term_en              = hwdata[CB_TERM];
          cfg_nxt.therm_dis            = hwdata[CB_TDIS];
          cfg_nxt.regulator_fault_mask = hwdata[CB_VMASK];
          cfg_nxt.recharge_offset      = hwdata[CB_RECH];
          cfg_nxt.fast_timer_limit     = hwdata[CB_LIM_LO +: 5];
          restart_nxt                  = hwdata[CB_RESTART];
        end
        ADDR_VOLT: begin
          cfg_nxt.charge_voltage_field = hwdata[10:0];
        end
        ADDR_CURR: begin
          cfg_nxt.fast_current_field  = hwdata[6:0];
          cfg_nxt.termination_current = hwdata[CUR_TERM +: 4];
        end
        default: begin
        end
      endcase
    end
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_CTRL: rdata_nxt = 32'({cfg_r.fast_timer_limit, cfg_r.recharge_offset,
                                   cfg_r.regulator_fault_mask, cfg_r.therm_dis,
                                   cfg_r.term_en});
        ADDR_VOLT: rdata_nxt = 32'(cfg_r.charge_voltage_field);
        ADDR_CURR: rdata_nxt = 32'({cfg_r.termination_current, 1'b0,
                                   cfg_r.fast_current_field});
        ADDR_STAT: rdata_nxt = 32'({pin_lvl, chg_en_r, cv_r, state_r});
        ADDR_TMR:  rdata_nxt = {fc_sec_r, lb_sec_r};
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r     <= '{term_en: 1'b0, therm_dis: 1'b0, regulator_fault_mask: 1'b0,
                     recharge_offset: 1'b0, fast_timer_limit: LIM_RST,
                     charge_voltage_field: CHGV_RST, fast_current_field: FASTCUR_RST,
                     termination_current: TERMCUR_RST};
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
      rdata_r   <= 32'h0000_0000;
      restart_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      wr_pend_r <= wr_pend_nxt;
      waddr_r   <= waddr_nxt;
      rdata_r   <= rdata_nxt;
      restart_r <= restart_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = rdata_r;

  // qualification counters: 0 up-low, 1 down-low, 2 term, 3 over-term, 4 below-good
  logic [4:0] q_cond;
  logic [4:0] q_clr;
  logic [4:0] q_done;

  assign q_cond = {sn.vbat_lt_good, !sn.icharge_lt_term, sn.icharge_lt_term,
                   !sn.vbat_gt_low, sn.vbat_gt_low};
  assign q_clr  = {state_r != charge_full_state, state_r != charge_full_state,
                   state_r != fast_charge_state, state_r != fast_charge_state,
                   state_r != precondition_state};

  generate
    for (genvar i = 0; i < 5; i++) begin : g_qual
      cftf_qualify #(
        .LIM (i == 2 ? TERM_CYC : QUAL_CYC)
      ) u_qual (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clr     (q_clr[i]),
        .cond    (q_cond[i]),
        .done_r  (q_done[i])
      );
    end
  endgenerate

  // second tick for the safety timers, half-second tick for blinking
  logic sec_tick;
  logic half_tick;
  logic blinking;

  assign blinking = (state_r == precondition_temp_hold) || (state_r == fast_temp_hold) ||
                    (state_r == full_temp_hold) || (state_r == fault_state);

  cftf_divider #(
    .N (SECOND)
  ) u_sec (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (1'b1),
    .pulse_r (sec_tick)
  );

  cftf_divider #(
    .N (BLINK_CYC)
  ) u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (blinking),
    .pulse_r (half_tick)
  );

  // condition decode
  logic        fatal;
  logic        temp_bad;
  logic        lb_exp;
  logic        fc_exp;
  logic [15:0] fc_lim_s;

  assign fatal    = sn.bat_ov || sn.vin_uv || sn.vin_ov ||
                    (sn.vreg_flt && !cfg_r.regulator_fault_mask);
  assign temp_bad = (sn.temp_hot || sn.temp_cold) && !cfg_r.therm_dis;
  assign lb_exp   = lb_sec_r >= 16'(LB_LIMIT_S);
  assign fc_lim_s = 16'(({11'h000, cfg_r.fast_timer_limit} + 16'h0001) * FC_STEP_S);
  assign fc_exp   = fc_sec_r >= fc_lim_s;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      precondition_state: begin
        if (fatal || lb_exp) state_nxt = fault_state;
        else if (temp_bad) state_nxt = precondition_temp_hold;
        else if (q_done[0]) state_nxt = fast_charge_state;
      end
      precondition_temp_hold: begin
        if (fatal) state_nxt = fault_state;
        else if (!temp_bad) state_nxt = precondition_state;
      end
      fast_charge_state: begin
        if (fatal || fc_exp) state_nxt = fault_state;
        else if (temp_bad) state_nxt = fast_temp_hold;
        else if (q_done[1]) state_nxt = precondition_state;
        else if (q_done[2]) begin
          state_nxt = cfg_r.term_en ? terminated_state : charge_full_state;
        end
      end
      fast_temp_hold: begin
        if (fatal) state_nxt = fault_state;
        else if (!temp_bad) state_nxt = fast_charge_state;
      end
      charge_full_state: begin
        if (fatal) state_nxt = fault_state;
        else if (temp_bad) state_nxt = full_temp_hold;
        else if (q_done[3] || q_done[4]) state_nxt = fast_charge_state;
      end
      full_temp_hold: begin
        if (fatal) state_nxt = fault_state;
        else if (!temp_bad) state_nxt = charge_full_state;
      end
      terminated_state: begin
        if (fatal || temp_bad) state_nxt = fault_state;
        else if (sn.vbat_lt_rech) state_nxt = fast_charge_state;
      end
      fault_state: begin
        if (restart_r) state_nxt = precondition_state;
      end
    endcase
  end

  // safety timers, outputs
  always_comb begin
    lb_sec_nxt = 16'h0000;
    fc_sec_nxt = 16'h0000;
    unique case (state_r)
      precondition_state: begin
        lb_sec_nxt = lb_sec_r + {15'h0000, sec_tick && !lb_exp};
      end
      precondition_temp_hold: begin
        lb_sec_nxt = lb_sec_r;
      end
      fast_charge_state: begin
        fc_sec_nxt = fc_sec_r + {15'h0000, sec_tick && !fc_exp};
      end
      fast_temp_hold: begin
        fc_sec_nxt = fc_sec_r;
      end
      fault_state: begin
        lb_sec_nxt = lb_sec_r;
        fc_sec_nxt = fc_sec_r;
      end
      default: begin
      end
    endcase
    blink_nxt  = blinking ? (blink_r ^ half_tick) : 1'b0;
    oe_n_nxt   = 1'b1;
    if (state_r == precondition_state || state_r == fast_charge_state) begin
      oe_n_nxt = 1'b0;
    end else if (blinking) begin
      oe_n_nxt = blink_r;
    end
    chg_en_nxt = (state_r == precondition_state) || (state_r == fast_charge_state) ||
                 (state_r == charge_full_state);
    cv_nxt     = (state_r == fast_charge_state || state_r == charge_full_state) &&
                 sn.vbat_at_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= precondition_state;
      lb_sec_r <= 16'h0000;
      fc_sec_r <= 16'h0000;
      blink_r  <= 1'b0;
      oe_n_r   <= 1'b1;
      chg_en_r <= 1'b0;
      cv_r     <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      lb_sec_r <= lb_sec_nxt;
      fc_sec_r <= fc_sec_nxt;
      blink_r  <= blink_nxt;
      oe_n_r   <= oe_n_nxt;
      chg_en_r <= chg_en_nxt;
      cv_r     <= cv_nxt;
    end
  end

  assign chg_stat_out  = 1'b0;
  assign chg_stat_oe_n = oe_n_r;
  assign charge_en     = chg_en_r;
  assign cv_mode       = cv_r;
  assign cfg_o         = cfg_r;
  assign state_o       = state_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pre_hold_go: assert property (
    state_r == precondition_state && !fatal && !lb_exp && temp_bad
    |=> state_r == precondition_temp_hold)
    else $error("precondition did not hold on bad temperature");

  a_lb_freeze: assert property (
    state_r == precondition_temp_hold |=> lb_sec_r == $past(lb_sec_r))
    else $error("low-battery timer moved during hold");

  a_therm_release: assert property (
    state_r == fast_temp_hold && cfg_r.therm_dis && !fatal |=> state_r == fast_charge_state)
    else $error("disabled thermistor did not release hold");

  a_pre_to_fast: assert property (
    state_r == precondition_state && !fatal && !lb_exp && !temp_bad && q_done[0]
    |=> state_r == fast_charge_state)
    else $error("qualified precondition did not go to fast charge");

  a_term_select: assert property (
    state_r == fast_charge_state && !fatal && !fc_exp && !temp_bad && !q_done[1]
    && q_done[2] |=> state_r == (cfg_r.term_en ? terminated_state : charge_full_state))
    else $error("completion went to wrong state");

  a_fast_fault: assert property (
    state_r == fast_charge_state && (fatal || fc_exp) |=> state_r == fault_state)
    else $error("fast charge fault not taken");

  a_fast_drive: assert property (
    state_r == fast_charge_state |=> !chg_stat_oe_n && !chg_stat_out)
    else $error("status not driven low in fast charge");

  a_full_zero: assert property (
    state_r == charge_full_state ##1 state_r == charge_full_state
    |-> fc_sec_r == 16'h0000 && lb_sec_r == 16'h0000 && chg_stat_oe_n)
    else $error("timers or status wrong in charge full");

  a_term_off: assert property (
    state_r == terminated_state |=> !charge_en)
    else $error("charge enabled while terminated");

  a_blink_toggle: assert property (
    state_r == fault_state && $past(state_r) == fault_state && half_tick
    |=> blink_r != $past(blink_r))
    else $error("fault blink did not toggle");

endmodule

//--- bench/cftf_battery.sv
// battery pack, thermistor and status pull-up as seen by the charger
`timescale 1ns/10ps
module cftf_battery
  import cftf_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // charger side
  input  wire logic        charge_en,
  input  wire logic        rech_hi,
  input  wire logic        oe_n,
  // pack conditions set by the bench
  input  wire logic [13:0] mv,
  input  wire logic [11:0] ma,
  input  wire logic [5:0]  flt,
  // to the charger
  output cftf_sense_t      sense,
  output logic             pin
);
  localparam int LOW_MV  = 6000;
  localparam int GOOD_MV = 7000;
  localparam int REG_MV  = 8400;
  localparam int TERM_MA = 200;
  // pull-up holds the released pin high
  assign pin = oe_n ? 1'b1 : 1'b0;
  initial sense = '0;
  always @(posedge hclk) begin
    sense.vbat_gt_low  <= mv > LOW_MV;
    sense.vbat_at_reg  <= mv >= REG_MV;
    sense.vbat_lt_good <= mv < GOOD_MV;
    // two cells: 200 or 300 mV below regulation
    sense.vbat_lt_rech <= mv < (REG_MV - (rech_hi ? 300 : 200));
    // no current flows while the charger is off
    sense.icharge_lt_term <= !charge_en || ma < TERM_MA;
    sense.temp_hot        <= flt[5];
    sense.temp_cold       <= flt[4];
    sense.bat_ov       <= flt[3];
    sense.vin_uv       <= flt[2];
    sense.vin_ov       <= flt[1];
    sense.vreg_flt     <= flt[0];
  end
endmodule

//--- bench/charger_fastcharge_term_fsm_tb.sv
// self-checking bench for the charge-control state machine
`timescale 1ns/10ps
module charger_fastcharge_term_fsm_tb;
  import cftf_pkg::*;
  localparam int QC = 8;
  localparam int TC = 20;
  localparam int SC = 10;
  localparam int BC = 4;
  localparam int QW = QC + 8;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, chg_stat_out, chg_stat_oe_n, charge_en, cv_mode, pin;
  logic        rd_ph = 1'b0;
  cftf_sense_t sense;
  cftf_cfg_t   cfg;
  cftf_state_t st;
  logic [13:0] mv = 14'd5000;
  logic [11:0] ma = 12'd1000;
  logic [5:0]  flt = 6'h00;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [31:0] t1, t2, v;
  int          mismatches = 0;
  int          comparisons = 0;

  always #4 hclk = ~hclk;

  cftf_charge_fsm #(.QUAL_CYC(QC), .TERM_CYC(TC), .SECOND(SC), .BLINK_CYC(BC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sense(sense), .chg_stat_in(pin),
    .chg_stat_out(chg_stat_out), .chg_stat_oe_n(chg_stat_oe_n), .charge_en(charge_en),
    .cv_mode(cv_mode), .cfg_o(cfg), .state_o(st));

  cftf_battery pack_m (
    .hclk(hclk), .charge_en(charge_en), .rech_hi(cfg.recharge_offset), .oe_n(chg_stat_oe_n),
    .mv(mv), .ma(ma), .flt(flt), .sense(sense), .pin(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // read data is compared against the oldest note
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) check(hrdata & mq.pop_front(), eq.pop_front());
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w) begin
      eq.push_back(d & m);
      mq.push_back(m);
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, t2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m, t2);
  endtask

  task automatic stq(input int s);
    rd(ADDR_STAT, 32'(s), 32'h7);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic set(input int m, input int a, input logic [5:0] f);
    @(posedge hclk);
    mv <= 14'(m);
    ma <= 12'(a);
    flt <= f;
  endtask

  task automatic blink;
    int n;
    logic p;
    n = 0;
    #1 p = chg_stat_oe_n;
    repeat (4 * BC) begin
      @(posedge hclk);
      #1;
      if (chg_stat_oe_n !== p) n++;
      p = chg_stat_oe_n;
    end
    check(32'(n), 32'd4);
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    mismatches++;
    close_out;
  end

  initial begin
    void'($urandom(92269));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'hB0, 32'h3FF);
    rd(ADDR_VOLT, 32'h400, 32'h7FF);
    rd(ADDR_CURR, 32'h264, 32'hF7F);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    v = $urandom;
    wr(ADDR_VOLT, v & 32'h7FF);
    wr(ADDR_CURR, v & 32'hF7F);
    cyc(2);
    check(32'(cfg.charge_voltage_field), v & 32'h7FF);
    check(32'({cfg.termination_current, cfg.fast_current_field}), 32'({v[11:8], v[6:0]}));
    // precondition hold freezes the low-battery count
    cyc(3 * SC);
    set(5000, 1000, 6'h20);
    cyc(6);
    stq(1);
    blink;
    bus(1'b0, ADDR_TMR, 32'h0, 32'h0, t1);
    cyc(3 * SC);
    bus(1'b0, ADDR_TMR, 32'h0, 32'h0, v);
    check(v, t1);
    check(32'(t1[15:0] == 16'h0), 32'h0);
    wr(ADDR_CTRL, 32'hB2);
    cyc(6);
    stq(0);
    set(5000, 1000, 6'h00);
    wr(ADDR_CTRL, 32'hB0);
    // a lapse restarts the qualification
    set(7000, 1000, 6'h00);
    cyc(QC - 2);
    set(5000, 1000, 6'h00);
    cyc(QW);
    stq(0);
    set(7000, 1000, 6'h00);
    cyc(QW);
    stq(2);
    rd(ADDR_TMR, 32'h0, 32'hFFFF);
    check(32'(chg_stat_oe_n), 32'h0);
    set(8500, 1000, 6'h00);
    cyc(6);
    rd(ADDR_STAT, 32'h18, 32'h18);
    set(8000, 1000, 6'h00);
    cyc(6);
    rd(ADDR_STAT, 32'h10, 32'h18);
    // fast hold freezes the fast-charge count
    cyc(3 * SC);
    set(8000, 1000, 6'h10);
    cyc(6);
    stq(3);
    bus(1'b0, ADDR_TMR, 32'h0, 32'h0, t1);
    cyc(3 * SC);
    bus(1'b0, ADDR_TMR, 32'h0, 32'h0, v);
    check(v, t1);
    check(32'(t1[31:16] == 16'h0), 32'h0);
    set(5000, 1000, 6'h00);
    cyc(QW);
    stq(0);
    set(8400, 100, 6'h00);
    cyc(QW + TC + 4);
    stq(4);
    rd(ADDR_TMR, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_STAT, 32'h20, 32'h20);
    set(8400, 100, 6'h20);
    cyc(6);
    stq(5);
    rd(ADDR_TMR, 32'h0, 32'hFFFF0000);
    set(8400, 100, 6'h00);
    cyc(6);
    stq(4);
    set(8400, 1000, 6'h00);
    cyc(QW);
    stq(2);
    set(8400, 100, 6'h00);
    cyc(TC + 8);
    stq(4);
    set(8400, 1000, 6'h08);
    cyc(6);
    stq(7);
    blink;
    set(8400, 1000, 6'h00);
    wr(ADDR_CTRL, 32'h2B0);
    cyc(4);
    stq(0);
    cyc(QW);
    stq(2);
    // each fault in fast charge, then a masked regulator fault
    for (int i = 0; i < 4; i++) begin
      set(8000, 1000, 6'h08 >> i);
      cyc(6);
      stq(7);
      set(8000, 1000, 6'h00);
      wr(ADDR_CTRL, 32'h2B0);
      cyc(QW);
      stq(2);
    end
    wr(ADDR_CTRL, 32'hB5);
    set(8000, 1000, 6'h01);
    cyc(6);
    stq(2);
    set(8400, 100, 6'h00);
    cyc(TC + 8);
    stq(6);
    rd(ADDR_STAT, 32'h0, 32'h10);
    set(8150, 100, 6'h00);
    cyc(6);
    stq(2);
    // shortest fast-charge limit
    set(8000, 1000, 6'h00);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h200);
    cyc(QW);
    cyc(17800);
    stq(2);
    cyc(400);
    stq(7);
    cyc(4);
    close_out;
  end
endmodule
